// ### include/fcsl_link_if.sv
// interface: serial configuration link between controller and front end
`timescale 1ns/1ps
`default_nettype none
interface fcsl_link_if;
   logic shift_clk;
   logic shift_data;
   logic shift_enable;
   logic update;
   logic readback;
   modport controller (output shift_clk, output shift_data, output shift_enable,
                       output update, input readback);
   modport frontend   (input shift_clk, input shift_data, input shift_enable,
                       input update, output readback);
endinterface
`default_nettype wire

// ### include/fcsl_pkg.sv
// package: constants and types of the front-end configuration loader
package fcsl_pkg;
   localparam int NUM_CHANNELS   = 8;
   localparam int CFG_BITS       = 53;
   localparam int THR_W          = 8;
   localparam int HYST_W         = 4;
   localparam int GATE_W         = 4;
   localparam int QTHR_W         = 3;
   localparam int RUNDOWN_W      = 3;
   localparam int DEAD_W         = 3;
   localparam int CAP_W          = 3;
   localparam int CHMODE_W       = 2;
   // field positions within the configuration word
   localparam int POS_CAL_MASK   = 0;
   localparam int POS_HYST       = 8;
   localparam int POS_THR        = 12;
   localparam int POS_CAP        = 20;
   localparam int POS_GATE       = 23;
   localparam int POS_RUNDOWN    = 27;
   localparam int POS_QTHR       = 30;
   localparam int POS_DEAD       = 33;
   localparam int POS_CHMODE     = 36;
   localparam int POS_CHIP_MODE  = 52;
   // channel mode and chip mode encodings
   localparam logic [1:0] CHMODE_ON          = 2'h0;
   localparam logic [1:0] CHMODE_FORCED_HIGH = 2'h1;
   localparam logic [1:0] CHMODE_FORCED_LOW  = 2'h2;
   localparam logic       CHIP_MODE_CHARGE   = 1'h0;
   localparam logic       CHIP_MODE_OVER_THR = 1'h1;
   // nominal codes loaded by the controller after reset
   localparam logic [7:0] NOM_THR     = 8'h6c; // 2*108-255 = -39 mV
   localparam logic [3:0] NOM_HYST    = 4'h2;
   localparam logic [3:0] NOM_GATE    = 4'h5; // 8 + 5*2.5 ~ 20 ns
   localparam logic [2:0] NOM_QTHR    = 3'h0;
   localparam logic [2:0] NOM_RUNDOWN = 3'h5;
   localparam logic [2:0] NOM_DEAD    = 3'h7;
   localparam logic [2:0] NOM_CAP     = 3'h0;
   localparam logic [7:0] NOM_CAL     = 8'h00;
   // value of the applied settings after reset: all channels low, quiet
   localparam logic [52:0] CFG_RESET  = {1'b0, {8{CHMODE_FORCED_LOW}}, 36'h0_0000_0000};
   // link timing in system clock cycles
   localparam int CLK_MHZ        = 100;
   localparam int LINK_HALF_NS   = 40;
   localparam int LINK_HALF_CYC  = (LINK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] LINK_HALF_LAST = 8'(LINK_HALF_CYC - 1);
   // controller register addresses
   localparam logic [3:0] ADDR_CTRL   = 4'h0; // w: bit0 load, bit1 nominal; r: bit0 busy
   localparam logic [3:0] ADDR_DATA0  = 4'h1; // bits 31:0 of the word
   localparam logic [3:0] ADDR_DATA1  = 4'h2; // bits 52:32 of the word
   localparam logic [3:0] ADDR_STATUS = 4'h3; // bit0 busy, bit1 boot pending, 31:16 loads
   // device timing of a conversion, base cycles and cycles per code step
   localparam logic [7:0] GATE_BASE_CYC = 8'h01;
   localparam logic [7:0] DEAD_BASE_CYC = 8'h02;
   localparam logic [7:0] DEAD_STEP_CYC = 8'h08;

   function automatic logic [52:0] fcsl_nominal();
      logic [52:0] w;
      w = '0;
      w[POS_CAL_MASK +: 8] = NOM_CAL;
      w[POS_HYST +: 4]     = NOM_HYST;
      w[POS_THR +: 8]      = NOM_THR;
      w[POS_CAP +: 3]      = NOM_CAP;
      w[POS_GATE +: 4]     = NOM_GATE;
      w[POS_RUNDOWN +: 3]  = NOM_RUNDOWN;
      w[POS_QTHR +: 3]     = NOM_QTHR;
      w[POS_DEAD +: 3]     = NOM_DEAD;
      w[POS_CHMODE +: 16]  = {8{CHMODE_ON}};
      w[POS_CHIP_MODE]     = CHIP_MODE_CHARGE;
      return w;
   endfunction
endpackage

// ### logic/fcsl_controller.sv
// module: link controller that shifts and applies configuration words
`timescale 1ns/1ps
`default_nettype none
module fcsl_controller
   import fcsl_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   fcsl_link_if.controller  link,
   input  wire logic [3:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      C_IDLE   = 4'b0001,
      C_LOW    = 4'b0010,
      C_HIGH   = 4'b0100,
      C_UPDATE = 4'b1000
   } fcsl_ctl_e;

   typedef struct packed {
      fcsl_ctl_e           fsm;
      logic [CFG_BITS-1:0] word;
      logic [CFG_BITS-1:0] shreg;
      logic [5:0]          bit_cnt;
      logic [7:0]          div;
      logic [15:0]         loads;
      logic                boot;
      logic                sclk;
      logic                sdat;
      logic                sen;
      logic                upd;
      logic [31:0]         rdata;
   } fcsl_ctl_s;

   fcsl_ctl_s st;
   fcsl_ctl_s next_st;

   always_comb begin
      logic tick;
      logic start;
      tick    = (st.div == LINK_HALF_LAST);
      start   = 1'b0;
      next_st = st;
      next_st.rdata = 32'h0000_0000;
      next_st.div   = tick ? 8'h00 : st.div + 8'h01;
      // ------------------------------------------------------------
      // register port
      // ------------------------------------------------------------
      if (wr_in) begin
         unique case (addr_in)
            ADDR_DATA0: next_st.word[31:0] = wdata_in;
            ADDR_DATA1: next_st.word[52:32] = wdata_in[20:0];
            ADDR_CTRL: begin
               if (wdata_in[1]) begin
                  next_st.word = fcsl_nominal();
               end
               start = wdata_in[0] | wdata_in[1];
            end
            default: ;
         endcase
      end
      if (rd_in) begin
         unique case (addr_in)
            ADDR_CTRL:   next_st.rdata = {31'h0, st.fsm != C_IDLE};
            ADDR_DATA0:  next_st.rdata = st.word[31:0];
            ADDR_DATA1:  next_st.rdata = {11'h0, st.word[52:32]};
            ADDR_STATUS: next_st.rdata = {st.loads, 14'h0, st.boot, st.fsm != C_IDLE};
            default:     next_st.rdata = 32'h0000_0000;
         endcase
      end
      // ------------------------------------------------------------
      // link sequencer: clock made here by a divider
      // ------------------------------------------------------------
      unique case (st.fsm)
         C_IDLE: begin
            next_st.upd = 1'b0;
            if (st.boot || start) begin
               next_st.boot    = 1'b0;
               next_st.shreg   = (st.boot && !start) ? fcsl_nominal() : next_st.word;
               next_st.bit_cnt = 6'(CFG_BITS);
               next_st.fsm     = C_LOW;
               next_st.div     = 8'h00;
            end
         end
         C_LOW: if (tick) begin
            next_st.sen  = 1'b1;
            next_st.sdat = st.shreg[0];
            next_st.fsm  = C_HIGH;
            next_st.sclk = 1'b0;
         end
         C_HIGH: if (tick) begin
            if (!st.sclk) begin
               next_st.sclk = 1'b1;
            end else begin
               next_st.sclk    = 1'b0;
               next_st.shreg   = {1'b0, st.shreg[CFG_BITS-1:1]};
               next_st.bit_cnt = st.bit_cnt - 6'h01;
               if (st.bit_cnt == 6'h01) begin
                  next_st.sen = 1'b0;
                  next_st.fsm = C_UPDATE;
               end else begin
                  next_st.sdat = st.shreg[1];
               end
            end
         end
         C_UPDATE: if (tick) begin
            if (!st.upd) begin
               next_st.upd = 1'b1;
            end else begin
               next_st.upd   = 1'b0;
               next_st.loads = st.loads + 16'h0001;
               next_st.fsm   = C_IDLE;
            end
         end
         default: next_st.fsm = C_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st      <= '0;
         st.fsm  <= C_IDLE;
         st.boot <= 1'b1; // nominal load right after reset
      end else begin
         st <= next_st;
      end
   end

   assign link.shift_clk    = st.sclk;
   assign link.shift_data   = st.sdat;
   assign link.shift_enable = st.sen;
   assign link.update       = st.upd;
   assign rdata_out         = st.rdata;
endmodule
`default_nettype wire

// ### logic/fcsl_frontend.sv
// module: front-end shift chain, shadow settings and output pulse composition
//
// Function
// - holds 53 configuration bits per chip
// - shift chain plus shadow register with control
// - controller makes data, control and clock
// - controller loads nominal values after reset
// - reload allowed at reset and run time
// - field widths eight, four, three bits
// - controller nominal gate, current, dead time
// - controller threshold code gives minus 39
// - second converter gets inverted threshold code
// - converter level equals reference plus code
// - differential threshold equals twice code minus 255
// - output pulse is gate OR rundown
// - rundown ends below charge threshold
// - leading edge time, width charge
// - global bit selects charge or threshold mode
// - per-channel mode on, high, low
// - dead time blocks input after pulse (charge mode only; in threshold mode the output follows the hit)
// - calibration mask selects pulsed channels
`timescale 1ns/1ps
`default_nettype none
module fcsl_frontend
   import fcsl_pkg::*;
(
   input  wire logic                    clk_in,
   input  wire logic                    rst_n_in,
   fcsl_link_if.frontend                link,
   input  wire logic [NUM_CHANNELS-1:0] disc_in,
   input  wire logic [NUM_CHANNELS-1:0] rundown_below_in,
   input  wire logic                    cal_pulse_in,
   output logic [NUM_CHANNELS-1:0]      chan_out,
   output logic [NUM_CHANNELS-1:0]      cal_inject_out,
   output logic [THR_W-1:0]             thr_code_p_out,
   output logic [THR_W-1:0]             thr_code_n_out,
   output logic signed [9:0]            thr_diff_mv_out,
   output logic [HYST_W-1:0]            hyst_code_out,
   output logic [QTHR_W-1:0]            qthr_code_out,
   output logic [RUNDOWN_W-1:0]         rundown_code_out,
   output logic [CAP_W-1:0]             cap_sel_out
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      CH_IDLE    = 4'b0001,
      CH_GATE    = 4'b0010,
      CH_RUNDOWN = 4'b0100,
      CH_DEAD    = 4'b1000
   } fcsl_ch_e;

   typedef struct packed {
      logic [2:0]                       sclk_sync;
      logic [1:0]                       sdat_sync;
      logic [1:0]                       sen_sync;
      logic [2:0]                       upd_sync;
      logic [NUM_CHANNELS-1:0][1:0]     disc_sync;
      logic [NUM_CHANNELS-1:0][1:0]     rd_sync;
      logic [1:0]                       cal_sync;
      logic [CFG_BITS-1:0]              chain;
      logic [CFG_BITS-1:0]              shadow;
      fcsl_ch_e [NUM_CHANNELS-1:0]      ch_state;
      logic [NUM_CHANNELS-1:0][7:0]     ch_count;
      logic                             readback;
      logic [NUM_CHANNELS-1:0]          chan;
      logic [NUM_CHANNELS-1:0]          cal_inject;
      logic [THR_W-1:0]                 thr_p;
      logic [THR_W-1:0]                 thr_n;
      logic signed [9:0]                thr_diff;
      logic [HYST_W-1:0]                hyst;
      logic [QTHR_W-1:0]                qthr;
      logic [RUNDOWN_W-1:0]             rundown;
      logic [CAP_W-1:0]                 cap;
   } fcsl_fe_s;

   fcsl_fe_s st;
   fcsl_fe_s next_st;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic                 sclk_rise;
      logic                 upd_rise;
      logic [GATE_W-1:0]    gate;
      logic [DEAD_W-1:0]    dead;
      logic [1:0]           mode;
      logic                 hit;
      logic                 below;
      logic                 pulse;
      sclk_rise = 1'b0;
      upd_rise  = 1'b0;
      gate      = '0;
      dead      = '0;
      mode      = '0;
      hit       = 1'b0;
      below     = 1'b0;
      pulse     = 1'b0;
      next_st   = st;
      // every link pin passes two flops before use
      next_st.sclk_sync = {st.sclk_sync[1:0], link.shift_clk};
      next_st.sdat_sync = {st.sdat_sync[0], link.shift_data};
      next_st.sen_sync  = {st.sen_sync[0], link.shift_enable};
      next_st.upd_sync  = {st.upd_sync[1:0], link.update};
      next_st.cal_sync  = {st.cal_sync[0], cal_pulse_in};
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         next_st.disc_sync[i] = {st.disc_sync[i][0], disc_in[i]};
         next_st.rd_sync[i]   = {st.rd_sync[i][0], rundown_below_in[i]};
      end
      sclk_rise = st.sclk_sync[1] & ~st.sclk_sync[2];
      upd_rise  = st.upd_sync[1] & ~st.upd_sync[2];
      // shift on the link clock rising edge, lsb of the chain out first
      if (sclk_rise && st.sen_sync[1]) begin
         next_st.chain    = {st.sdat_sync[1], st.chain[CFG_BITS-1:1]};
         next_st.readback = st.chain[0];
      end
      // applied settings move only on update, never mid-shift
      if (upd_rise && !st.sen_sync[1]) begin
         next_st.shadow = st.chain;
      end
      // analog control codes from the applied settings
      next_st.thr_p    = st.shadow[POS_THR +: THR_W];
      next_st.thr_n    = ~st.shadow[POS_THR +: THR_W];
      next_st.thr_diff = 10'(signed'({2'b00, st.shadow[POS_THR +: THR_W]}) * 2
                         - 10'sd255);
      next_st.hyst     = st.shadow[POS_HYST +: HYST_W];
      next_st.qthr     = st.shadow[POS_QTHR +: QTHR_W];
      next_st.rundown  = st.shadow[POS_RUNDOWN +: RUNDOWN_W];
      next_st.cap      = st.shadow[POS_CAP +: CAP_W];
      gate = st.shadow[POS_GATE +: GATE_W];
      dead = st.shadow[POS_DEAD +: DEAD_W];
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         hit   = st.disc_sync[i][1];
         below = st.rd_sync[i][1];
         mode  = st.shadow[POS_CHMODE + 2*i +: 2];
         next_st.cal_inject[i] = st.cal_sync[1] & st.shadow[POS_CAL_MASK + i];
         unique case (st.ch_state[i])
            CH_IDLE: begin
               if (hit) begin
                  next_st.ch_state[i] = CH_GATE;
                  next_st.ch_count[i] = GATE_BASE_CYC + 8'(gate);
               end
            end
            CH_GATE: begin
               if (st.ch_count[i] == 8'h00) begin
                  next_st.ch_state[i] = CH_RUNDOWN;
               end else begin
                  next_st.ch_count[i] = st.ch_count[i] - 8'h01;
               end
            end
            CH_RUNDOWN: begin
               if (below) begin
                  next_st.ch_state[i] = CH_DEAD;
                  next_st.ch_count[i] = DEAD_BASE_CYC + 8'(dead) * DEAD_STEP_CYC;
               end
            end
            CH_DEAD: begin
               if (st.ch_count[i] == 8'h00) begin
                  next_st.ch_state[i] = CH_IDLE;
               end else begin
                  next_st.ch_count[i] = st.ch_count[i] - 8'h01;
               end
            end
            default: begin
               next_st.ch_state[i] = CH_IDLE;
            end
         endcase
         // leading edge at the hit, width spans gate plus rundown
         pulse = (st.ch_state[i] == CH_GATE) | (st.ch_state[i] == CH_RUNDOWN);
         if (st.shadow[POS_CHIP_MODE] == CHIP_MODE_OVER_THR) begin
            pulse = hit;
         end
         unique case (mode)
            CHMODE_FORCED_HIGH: next_st.chan[i] = 1'b1;
            CHMODE_FORCED_LOW:  next_st.chan[i] = 1'b0;
            default:            next_st.chan[i] = pulse;
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st          <= '0;
         st.shadow   <= CFG_RESET;
         st.ch_state <= {NUM_CHANNELS{CH_IDLE}};
         st.thr_n    <= 8'hff;
         st.thr_diff <= -10'sd255;
      end else begin
         st <= next_st;
      end
   end

   assign link.readback    = st.readback;
   assign chan_out         = st.chan;
   assign cal_inject_out   = st.cal_inject;
   assign thr_code_p_out   = st.thr_p;
   assign thr_code_n_out   = st.thr_n;
   assign thr_diff_mv_out  = st.thr_diff;
   assign hyst_code_out    = st.hyst;
   assign qthr_code_out    = st.qthr;
   assign rundown_code_out = st.rundown;
   assign cap_sel_out      = st.cap;
endmodule
`default_nettype wire

// ### testbench/fcsl_link_assertions.sv
// checker: timing and framing of the serial configuration link
`timescale 1ns/1ps
`default_nettype none
module fcsl_link_assertions
   import fcsl_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic shift_clk,
   input  wire logic shift_data,
   input  wire logic shift_enable,
   input  wire logic update,
   input  wire logic readback
);
   // ------------------------------------------------------------
   // helper: rising link clock edges counted within one frame
   // ------------------------------------------------------------
   logic       clk_q;
   logic [7:0] bit_cnt;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         clk_q   <= 1'b0;
         bit_cnt <= 8'h00;
      end else begin
         clk_q <= shift_clk;
         if (!shift_enable) begin
            bit_cnt <= 8'h00;
         end else if (shift_clk && !clk_q) begin
            bit_cnt <= bit_cnt + 8'h01;
         end
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_clk_high;
      shift_clk [*4] ##1 !shift_clk;
   endsequence
   sequence s_upd_pulse;
      update [*4] ##1 !update;
   endsequence
   sequence s_upd_start;
      ##[0:16] $rose(update);
   endsequence
   chk_update_enable_low: assert property (update |-> !shift_enable)
      else $error("update raised inside a frame");
   chk_update_pulse_len: assert property ($rose(update) |-> s_upd_pulse)
      else $error("update pulse not one half period");
   chk_update_after_frame: assert property ($fell(shift_enable) |-> s_upd_start)
      else $error("no update after frame");
   chk_clk_high_len: assert property ($rose(shift_clk) |-> s_clk_high)
      else $error("link clock high phase wrong");
   chk_clk_low_len: assert property ($rose(shift_clk) |-> $past(shift_clk, 4) == 1'b0)
      else $error("link clock low phase too short");
   chk_data_stable_high: assert property (shift_clk |-> $stable(shift_data))
      else $error("data moved while link clock high");
   chk_clk_in_frame: assert property (shift_clk |-> shift_enable)
      else $error("link clock outside frame");
   chk_frame_bit_count: assert property ($fell(shift_enable) |-> bit_cnt == 8'(CFG_BITS))
      else $error("frame bit count wrong");
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// testbench: both link ends joined, driven through the controller registers
`timescale 1ns/1ps
`default_nettype none
module testbench
   import fcsl_pkg::*;
;
   logic              clk_in      = 1'b0;
   logic              rst_n_in    = 1'b0;
   logic [3:0]        addr        = 4'h0;
   logic [31:0]       wdata       = 32'h0000_0000;
   logic              wr          = 1'b0;
   logic              rd          = 1'b0;
   logic [7:0]        disc        = 8'h00;
   logic [7:0]        below       = 8'h00;
   logic              cal_pulse   = 1'b0;
   logic [31:0]       rdata;
   logic [7:0]        chan;
   logic [7:0]        cal_inj;
   logic [7:0]        thr_p;
   logic [7:0]        thr_n;
   logic signed [9:0] thr_diff;
   logic [3:0]        hyst;
   logic [2:0]        qthr;
   logic [2:0]        rundown;
   logic [2:0]        cap;
   int                miscompares = 0;
   int                cmp_count   = 0;
   int                cycles      = 0;

   always #5 clk_in = ~clk_in;

   fcsl_link_if link ();
   fcsl_controller i_fcsl_controller (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
   fcsl_frontend i_fcsl_frontend (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
      .disc_in(disc), .rundown_below_in(below), .cal_pulse_in(cal_pulse), .chan_out(chan),
      .cal_inject_out(cal_inj), .thr_code_p_out(thr_p), .thr_code_n_out(thr_n),
      .thr_diff_mv_out(thr_diff), .hyst_code_out(hyst), .qthr_code_out(qthr),
      .rundown_code_out(rundown), .cap_sel_out(cap));
   fcsl_link_assertions i_fcsl_link_assertions (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .shift_clk(link.shift_clk), .shift_data(link.shift_data),
      .shift_enable(link.shift_enable), .update(link.update), .readback(link.readback));

   // ------------------------------------------------------------
   // access and comparison tasks
   // ------------------------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic reg_wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(logic [3:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // bounded poll: a load is 53 bits of 8 cycles plus the update
   task automatic wait_idle();
      logic [31:0] s;
      s = 32'h0000_0001;
      for (int i = 0; i < 1000 && s[0] !== 1'b0; i++) reg_rd(ADDR_STATUS, s);
      check("busy", s & 32'h0000_0001, 32'h0000_0000);
      repeat (10) @(posedge clk_in);
   endtask
   // dead 7, gate 5; analog fields derived from the threshold code, modes and cal mask given
   function automatic logic [52:0] mkword(logic [7:0] t, logic [15:0] m, logic chip,
                                          logic [7:0] cal);
      return {chip, m, 3'h7, t[2:0], t[5:3], 4'h5, ~t[2:0], t, t[7:4], cal};
   endfunction
   task automatic load(logic [52:0] w);
      reg_wr(ADDR_DATA0, w[31:0]);
      reg_wr(ADDR_DATA1, {11'h000, w[52:32]});
      reg_wr(ADDR_CTRL, 32'h0000_0001);
   endtask
   task automatic check_fields(logic [7:0] t);
      logic [7:0] tn;
      logic [2:0] cn;
      logic [9:0] d;
      tn = ~t;
      cn = ~t[2:0];
      d  = 10'(2 * int'(t) - 255);
      check("thr_p", thr_p, t);
      check("thr_n", thr_n, tn);
      check("thr_diff", thr_diff[9:0], d);
      check("hyst", hyst, t[7:4]);
      check("qthr", qthr, t[2:0]);
      check("rundown", rundown, t[5:3]);
      check("cap", cap, cn);
      check("cal_inj", cal_inj, t);
   endtask
   task automatic hit(int n, output logic seen);
      seen = 1'b0;
      disc <= 8'h04;
      for (int i = 0; i < n; i++) begin
         @(posedge clk_in);
         if (i == 3) disc <= 8'h00;
         seen |= chan[2];
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   logic [7:0] codes [4] = '{8'h00, 8'hff, 8'h80, 8'h01};
   logic [7:0] over_in [2] = '{8'hf2, 8'h0c};
   logic [7:0] over_ex [2] = '{8'hf1, 8'h0d};
   initial begin
      logic [31:0] r;
      logic [7:0]  prev;
      logic        s;
      repeat (2) @(posedge clk_in);
      check("rst_thr_p", thr_p, 32'h0000_0000);
      check("rst_thr_n", thr_n, 32'h0000_00ff);
      check("rst_diff", thr_diff[9:0], 32'h0000_0301);
      check("rst_chan", chan, 32'h0000_0000);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      wait_idle();
      check("nom_thr", thr_p, NOM_THR);
      check("nom_diff", thr_diff[9:0], 32'h0000_03d9);
      check("nom_hyst", hyst, NOM_HYST);
      check("nom_rundown", rundown, NOM_RUNDOWN);
      reg_rd(ADDR_STATUS, r);
      // one load counted, boot flag already cleared, idle
      check("boot_done", r, 32'h0001_0000);
      reg_rd(4'hf, r);
      check("unmapped", r, 32'h0000_0000);
      cal_pulse <= 1'b1;
      prev = NOM_THR;
      foreach (codes[i]) begin
         load(mkword(codes[i], 16'h0000, CHIP_MODE_CHARGE, codes[i]));
         repeat (100) @(posedge clk_in);
         check("hold_thr", thr_p, prev);
         wait_idle();
         check_fields(codes[i]);
         prev = codes[i];
      end
      // ch0 forced high, ch1 forced low, others follow the discriminator
      load(mkword(8'h6c, 16'h0009, CHIP_MODE_OVER_THR, 8'h00));
      wait_idle();
      check("readback_0", link.readback, 32'h0000_0000);
      foreach (over_in[i]) begin
         disc <= over_in[i];
         repeat (10) @(posedge clk_in);
         check("over_chan", chan, over_ex[i]);
      end
      disc <= 8'h00;
      // hits above left channels in rundown: end the ramp during the reload
      below <= 8'hff;
      load(mkword(8'h6c, 16'h0000, CHIP_MODE_CHARGE, 8'h00));
      wait_idle();
      below <= 8'h00;
      // last bit out of the chain is the chip mode of the word before
      check("readback_1", link.readback, 32'h0000_0001);
      check("idle_chan", chan, 32'h0000_0000);
      hit(16, s);
      check("hit_seen", s, 32'h0000_0001);
      repeat (20) @(posedge clk_in);
      check("rundown_hold", chan, 32'h0000_0004);
      below <= 8'hff;
      repeat (6) @(posedge clk_in);
      check("rundown_end", chan, 32'h0000_0000);
      hit(20, s);
      check("dead_block", s, 32'h0000_0000);
      repeat (60) @(posedge clk_in);
      hit(16, s);
      check("after_dead", s, 32'h0000_0001);
      print_verdict();
   end

   // hang guard: whole run is well under this many cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
endmodule
`default_nettype wire
